/* logic/chop_sequencer.sv */
// chop conversion sequencer: timing, polarity swap and result pipeline
// assumes the modulator/filter core returns a raw word with rawStb after the end
// of each sampling phase, and the serial port decodes start commands into
// startCmd on the seventh falling clock edge of the command
//
// What this block does
// - chop result built from two conversions
// - first normal polarity, then inputs swapped
// - output is mean of both polarities
// - one enable bit switches chop
// - low-latency chop first data near two periods
// - sinc3 chop first data near six periods
// - later low-latency chop conversions take half time
// - pipelined average on every low-latency data cycle
// - low-latency chop period counts at 20 and 4000 SPS
// - line rejection only at 60 SPS or less
// - 20 SPS low-latency rejects 50 and 60 Hz
// - settling delay applied to both conversions
// - start on pin rise or command
// - swap on first settled data, then average
`timescale 1ns/1ps
module chop_sequencer import gchop_pkg::*; (
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   input  wire logic                       chopEn,      // chop enable bit of the rate register
   input  wire logic                       sinc3Sel,    // 1: sinc3 filter, 0: low latency
   input  wire logic                       contMode,    // 1: continuous, 0: single shot
   input  wire logic [RATE_W-1:0]          rateSel,     // data rate code
   input  wire logic [DLY_W-1:0]           delaySel,    // settling delay code
   input  wire logic                       startPin,    // start/sync pin level
   input  wire logic                       startCmd,    // decoded start command pulse
   input  wire logic                       stopReq,     // stop continuous conversions
   input  wire logic                       rawStb,      // raw filter result valid
   input  wire logic signed [RESULT_W-1:0] rawData,     // raw filter result
   output logic                            inputSwap,   // input polarity reversed
   output logic                            sampling,    // modulator sampling phase
   output logic                            convBusy,    // conversion in progress
   output logic                            lineReject,  // filter has line notches
   output logic signed [RESULT_W-1:0]      dataOut,     // final result
   output logic                            dataReady,   // one-cycle result strobe
   output logic [CNT_W-1:0]                periodLen    // active period, modulator periods
);
   seq_state_e       state_r, state_nxt;   // sequencer state
   logic             pinQ_r;               // start pin last level
   logic             startEv;              // start event
   logic             tick;                 // modulator period tick
   logic [CNT_W-1:0] cnt_r;                // period counter
   logic [CNT_W-1:0] cnt_nxt;
   logic [2:0]       settle_r;             // conversions left to settle
   logic             first_r;              // still on the first data
   logic             swap_r;               // polarity for this conversion
   logic [CNT_W-1:0] nomPer;               // nominal data period
   logic [CNT_W-1:0] dlyLen;               // settling delay length
   logic [2:0]       settleNeed;           // conversions before data are settled
   logic             settled;              // this raw word is settled
   logic             avgStb;               // averaged word valid
   logic signed [RESULT_W-1:0] avgData;    // averaged word
   logic             periodEnd;            // sampling phase ends this tick
   logic             stopNow;              // sequence ends after this conversion
   logic             plainStb;             // settled result without chop
   logic             lastSwap_r;           // polarity of the conversion just ended
   logic             lastSettled_r;        // conversion just ended gave settled data

   // start on pin rising edge or command
   assign startEv    = (startPin && !pinQ_r) || startCmd;
   assign nomPer     = nominal_period(rateSel);
   // delay doubles from the base for every code step
   assign dlyLen     = (delaySel == '0) ? DLY_BASE : (DLY_BASE << delaySel);
   // sinc3 needs three, low-latency one conversion to settle
   assign settleNeed = sinc3Sel ? SINC3_SETTLE : LL_SETTLE;
   assign settled    = (settle_r <= 3'h1);
   // line notches only at 60 SPS and below; 20 SPS low latency reaches ~-95 dB
   assign lineReject = (rateSel <= RATE_60SPS);
   assign periodEnd  = (state_r == ST_SAMPLE) && tick && (cnt_r == '0);
   assign stopNow    = !contMode || stopReq;
   assign sampling   = (state_r == ST_SAMPLE);
   assign convBusy   = (state_r != ST_IDLE);
   assign inputSwap  = swap_r;
   // the raw word lands after period end, when swap and settle have moved on,
   // so it is judged by what was latched for the conversion that made it
   assign plainStb   = rawStb && lastSettled_r && !chopEn;

   mod_tick u_tick (
      .core_clk (core_clk),
      .rstn     (rstn),
      .restart  (startEv),
      .tick     (tick)
   );

   chop_average u_avg (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clear    (startEv || !chopEn),
      .inStb    (rawStb && lastSettled_r && chopEn),
      .inInv    (lastSwap_r),
      .inData   (rawData),
      .avgData  (avgData),
      .avgStb   (avgStb)
   );

   // state sequencing: delay, sample, then repeat or stop
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (startEv) begin
               state_nxt = ST_DELAY;
               cnt_nxt   = dlyLen;
            end
         end
         ST_DELAY: begin
            if (tick) begin
               if (cnt_r == '0) begin
                  state_nxt = ST_SAMPLE;
                  // every chop conversion is a full single-shot, overhead included
                  cnt_nxt   = nomPer + ((first_r || chopEn) ? OVERHEAD : '0);
               end else cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_SAMPLE: begin
            if (tick) begin
               if (cnt_r == '0) begin
                  state_nxt = ST_DONE;
               end else cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_DONE: begin
            // chop re-settles with the delay every conversion; plain
            // continuous mode goes straight into the next period
            if (stopNow && (!chopEn || !first_r || settle_r == '0)) begin
               state_nxt = ST_IDLE;
            end else if (chopEn) begin
               state_nxt = ST_DELAY;
               cnt_nxt   = dlyLen;
            end else begin
               state_nxt = ST_SAMPLE;
               cnt_nxt   = nomPer;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (startEv) begin
         state_nxt = ST_DELAY;
         cnt_nxt   = dlyLen;
      end
   end

   // state and counter registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
         pinQ_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         pinQ_r  <= startPin;
      end
   end

   // settling and polarity tracking
   // first result of chop needs settled data in both polarities, so the
   // first output waits two settled conversions: ~2 or ~6 periods
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         settle_r      <= '0;
         first_r       <= 1'b1;
         swap_r        <= 1'b0;
         lastSwap_r    <= 1'b0;
         lastSettled_r <= 1'b0;
      end else if (startEv) begin
         settle_r      <= settleNeed;
         first_r       <= 1'b1;
         swap_r        <= 1'b0;
         lastSwap_r    <= 1'b0;
         lastSettled_r <= 1'b0;
      end else if (periodEnd) begin
         lastSwap_r    <= swap_r;
         lastSettled_r <= settled;
         if (settle_r > 3'h1) settle_r <= settle_r - 1'b1;
         else begin
            // swap only on settled data, and only with chop on
            if (chopEn) swap_r <= !swap_r;
            if (chopEn && swap_r) first_r <= 1'b0;
            if (!chopEn) first_r <= 1'b0;
            if (chopEn && !swap_r) settle_r <= settleNeed;         // settle again after swap to reversed inputs
         end
      end else if (!chopEn) begin
         swap_r <= 1'b0;
      end
   end

   // output register: averaged word in chop, raw word otherwise
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dataOut   <= '0;
         dataReady <= 1'b0;
      end else begin
         dataReady <= avgStb || plainStb;
         if (avgStb)        dataOut <= avgData;
         else if (plainStb) dataOut <= rawData;
      end
   end

   // reported period: first chop data is twice the later period
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) periodLen <= '0;
      else if (chopEn && rateSel == RATE_20SPS && !sinc3Sel)
         periodLen <= first_r ? CHOP_20_FIRST : CHOP_20_NEXT;
      else if (chopEn && rateSel == RATE_4000SPS && !sinc3Sel)
         periodLen <= first_r ? CHOP_4K_FIRST : CHOP_4K_NEXT;
      else if (chopEn)
         periodLen <= first_r ? 20'((nomPer + OVERHEAD + dlyLen) << 1)
                              : 20'(nomPer + OVERHEAD + dlyLen);
      else
         periodLen <= first_r ? 20'(nomPer + OVERHEAD) : nomPer;
   end
   // chopEn is the single rate-register enable bit driving all of the above
endmodule

/* shared/gchop_pkg.sv */
// constants and types for the chop conversion sequencer
// assumes a single 10 MHz core clock; modulator period is 16 clock periods
package gchop_pkg;
   localparam int          RESULT_W      = 24;           // conversion word width
   localparam int          MOD_DIV       = 16;           // clocks per modulator_period
   localparam int          MOD_DIV_W     = 4;
   localparam int          CNT_W         = 20;           // modulator-period counter width
   localparam int          RATE_W        = 4;            // data rate select width
   localparam int          DLY_W         = 3;            // settling delay select width
   localparam logic [3:0]  RATE_60SPS    = 4'h6;         // highest code with line rejection
   localparam logic [3:0]  RATE_20SPS    = 4'h4;
   localparam logic [3:0]  RATE_4000SPS  = 4'hd;
   localparam logic [2:0]  SINC3_SETTLE  = 3'h3;         // sinc3 settles over three data
   localparam logic [2:0]  LL_SETTLE     = 3'h1;         // low-latency settles in one
   localparam logic [CNT_W-1:0] DLY_BASE = 20'h0000e;    // default delay, 14 periods
   localparam logic [CNT_W-1:0] OVERHEAD = 20'h00041;    // first-data overhead, 65 periods
   localparam logic [CNT_W-1:0] CHOP_20_FIRST = 20'h07102; // 28930 periods at 20 SPS
   localparam logic [CNT_W-1:0] CHOP_20_NEXT  = 20'h03881; // 14465 periods at 20 SPS
   localparam logic [CNT_W-1:0] CHOP_4K_FIRST = 20'h000d0; // 208 periods at 4000 SPS
   localparam logic [CNT_W-1:0] CHOP_4K_NEXT  = 20'h00068; // 104 periods at 4000 SPS

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_DELAY  = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_DONE   = 3'b011
   } seq_state_e;

   // nominal data period in modulator periods, one entry per rate code
   function automatic logic [CNT_W-1:0] nominal_period(input logic [RATE_W-1:0] rate);
      logic [CNT_W-1:0] p;
      p = 20'h0;
      case (rate)
         4'h0: p = 20'h19000; 4'h1: p = 20'h0c800; 4'h2: p = 20'h06400;
         4'h3: p = 20'h03c00; 4'h4: p = 20'h03200; 4'h5: p = 20'h01400;
         4'h6: p = 20'h010a8; 4'h7: p = 20'h00a00; 4'h8: p = 20'h00500;
         4'h9: p = 20'h00280; 4'ha: p = 20'h00140; 4'hb: p = 20'h00100;
         4'hc: p = 20'h00080; default: p = 20'h00040;
      endcase
      return p;
   endfunction
endpackage

/* logic/mod_tick.sv */
// modulator-period tick generator
// assumes core_clk free running; tick is one core_clk wide every MOD_DIV clocks
`timescale 1ns/1ps
module mod_tick import gchop_pkg::*; (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic restart,      // realign the phase at conversion start
   output logic      tick
);
   logic [MOD_DIV_W-1:0] div_r;    // clock divider
   logic [MOD_DIV_W-1:0] div_nxt;
   assign div_nxt = restart ? '0 : div_r + 1'b1;
   assign tick    = (div_r == MOD_DIV_W'(MOD_DIV - 1));
   // divider runs always; restart keeps the first period whole
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) div_r <= '0;
      else       div_r <= div_nxt;
   end
endmodule

/* logic/chop_average.sv */
// averaging stage for pairs of opposite-polarity results
// assumes signed two's-complement inputs, one strobe per finished conversion
`timescale 1ns/1ps
module chop_average import gchop_pkg::*; (
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   input  wire logic                       clear,    // drop the held sample
   input  wire logic                       inStb,    // raw result valid
   input  wire logic                       inInv,    // raw taken with swapped inputs
   input  wire logic signed [RESULT_W-1:0] inData,   // raw result
   output logic signed [RESULT_W-1:0]      avgData,  // averaged result
   output logic                            avgStb    // one-cycle valid
);
   logic signed [RESULT_W-1:0] prev_r;               // last polarity-corrected result
   logic                       have_r;               // prev_r holds a sample
   logic signed [RESULT_W:0]   sum;                  // one guard bit avoids overflow
   logic signed [RESULT_W-1:0] corr;                 // swapped sample turned back
   assign corr = inInv ? -inData : inData;
   assign sum  = {prev_r[RESULT_W-1], prev_r} + {corr[RESULT_W-1], corr};
   // each new sample averages with the one before, so every cycle yields data
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prev_r  <= '0;
         have_r  <= 1'b0;
         avgData <= '0;
         avgStb  <= 1'b0;
      end else begin
         avgStb <= inStb && have_r && !clear;
         if (inStb && have_r) avgData <= sum[RESULT_W:1];
         if (clear) have_r <= 1'b0;
         else if (inStb) begin
            prev_r <= corr;
            have_r <= 1'b1;
         end
      end
   end
endmodule

/* tb/chop_sequencer_assertions.sv */
// port-level checks for the chop conversion sequencer
// assumes one core_clk domain and bind onto every chop_sequencer instance
`timescale 1ns/1ps
module chop_sequencer_assertions import gchop_pkg::*; (
   input wire logic                       core_clk,
   input wire logic                       rstn,
   input wire logic                       chopEn,
   input wire logic [RATE_W-1:0]          rateSel,
   input wire logic                       startPin,
   input wire logic                       startCmd,
   input wire logic                       rawStb,
   input wire logic                       sampling,
   input wire logic                       inputSwap,
   input wire logic                       convBusy,
   input wire logic                       lineReject,
   input wire logic signed [RESULT_W-1:0] dataOut,
   input wire logic                       dataReady
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // a start taken from the pin edge or the decoded command
   sequence s_start;
      (startPin && !$past(startPin)) || startCmd;
   endsequence
   a_line_reject: assert property (lineReject == (rateSel <= RATE_60SPS))
      else $error("line rejection flag wrong for rate code");
   a_no_swap: assert property (!chopEn |-> !inputSwap)
      else $error("inputs swapped with chop off");
   a_swap_chop_only: assert property ($changed(inputSwap) |-> chopEn)
      else $error("polarity changed without chop enable");
   a_swap_steady: assert property (sampling && $past(sampling) |-> $stable(inputSwap))
      else $error("polarity changed inside a sampling phase");
   a_first_normal: assert property ($rose(convBusy) && chopEn |-> !inputSwap)
      else $error("first chop conversion not in normal polarity");
   a_ready_cause: assert property (dataReady |-> $past(rawStb) || $past(rawStb, 2))
      else $error("result strobe without a raw result");
   a_ready_pulse: assert property (dataReady |=> !dataReady)
      else $error("result strobe longer than one cycle");
   a_out_hold: assert property ($changed(dataOut) |-> dataReady)
      else $error("result changed without strobe");
   a_start_busy: assert property (s_start |-> ##[1:2] convBusy)
      else $error("start did not begin a conversion");
endmodule

bind chop_sequencer chop_sequencer_assertions i_chk (
   .core_clk(core_clk), .rstn(rstn), .chopEn(chopEn), .rateSel(rateSel),
   .startPin(startPin), .startCmd(startCmd), .rawStb(rawStb), .sampling(sampling),
   .inputSwap(inputSwap), .convBusy(convBusy), .lineReject(lineReject),
   .dataOut(dataOut), .dataReady(dataReady)
);

/* tb/front_end_model.sv */
// behavioural modulator and filter front end feeding raw words
// assumes one raw word is due in the cycle after each sampling phase ends
`timescale 1ns/1ps
module front_end_model import gchop_pkg::*; (
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   input  wire logic                       sampling,
   input  wire logic                       inputSwap,
   input  wire logic signed [RESULT_W-1:0] sigVal,
   input  wire logic signed [RESULT_W-1:0] ofsVal,
   output logic                            rawStb,
   output logic signed [RESULT_W-1:0]      rawData
);
   logic sampPrev_r;   // sampling one cycle ago
   logic swapSeen_r;   // polarity held during the last sampling phase
   // offset stays put while the signal follows the input polarity
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sampPrev_r <= 1'b0;
         swapSeen_r <= 1'b0;
         rawStb     <= 1'b0;
         rawData    <= '0;
      end else begin
         sampPrev_r <= sampling;
         if (sampling) swapSeen_r <= inputSwap;
         rawStb <= sampPrev_r && !sampling;
         // word is only valid with the strobe; otherwise it churns every cycle
         if (sampPrev_r && !sampling) begin
            rawData <= swapSeen_r ? ofsVal - sigVal : ofsVal + sigVal;
         end else begin
            rawData <= ~rawData;
         end
      end
   end
endmodule

/* tb/global_chop_conversion_sequencer_tb_top.sv */
// self-checking bench for the chop conversion sequencer
// assumes the front end model answers each sampling phase; 4000 SPS keeps runs short
`timescale 1ns/1ps
module global_chop_conversion_sequencer_tb_top import gchop_pkg::*;;
   localparam logic signed [RESULT_W-1:0] SIG = 24'h001234; // input signal
   localparam logic signed [RESULT_W-1:0] OFS = 24'h000a50; // internal_offset_voltage
   logic                       core_clk, rstn, chopEn, sinc3Sel, contMode;
   logic [RATE_W-1:0]          rateSel;
   logic [DLY_W-1:0]           delaySel;
   logic                       startPin, startCmd, stopReq, rawStb;
   logic signed [RESULT_W-1:0] rawData, dataOut;
   logic                       inputSwap, sampling, convBusy, lineReject, dataReady;
   logic [CNT_W-1:0]           periodLen;
   int                         errors, compares, t1, t2, ts;

   chop_sequencer i_dut (.core_clk(core_clk), .rstn(rstn), .chopEn(chopEn),
      .sinc3Sel(sinc3Sel), .contMode(contMode), .rateSel(rateSel), .delaySel(delaySel),
      .startPin(startPin), .startCmd(startCmd), .stopReq(stopReq), .rawStb(rawStb),
      .rawData(rawData), .inputSwap(inputSwap), .sampling(sampling), .convBusy(convBusy),
      .lineReject(lineReject), .dataOut(dataOut), .dataReady(dataReady),
      .periodLen(periodLen));
   front_end_model i_fe (.core_clk(core_clk), .rstn(rstn), .sampling(sampling),
      .inputSwap(inputSwap), .sigVal(SIG), .ofsVal(OFS), .rawStb(rawStb), .rawData(rawData));

   // free running 10 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic cmp_word(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single exit of the run
   task automatic test_done();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // fresh reset per scenario so polarity and held samples start clean
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
   endtask

   // one-cycle start on the pin or as a decoded command
   task automatic kick(input logic viaPin);
      @(posedge core_clk);
      if (viaPin) startPin <= 1'b1;
      else startCmd <= 1'b1;
      @(posedge core_clk);
      startPin <= 1'b0;
      startCmd <= 1'b0;
   endtask

   // counts cycles to the next result strobe; a spent bound ends the run
   task automatic wait_ready(input int bound, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
         if (n > bound) begin
            errors++;
            test_done();
         end
      end while (dataReady !== 1'b1);
   endtask

   // flag is purely a function of the rate code
   task automatic sc_line_reject();
      for (int r = 0; r < 14; r++) begin
         @(posedge core_clk);
         rateSel <= r[RATE_W-1:0];
         @(posedge core_clk);
         #1;
         cmp_flag(lineReject, r[RATE_W-1:0] <= RATE_60SPS);
      end
   endtask

   // chop off: raw word passes straight through, no swap
   task automatic sc_plain();
      chopEn <= 1'b0;
      contMode <= 1'b0;
      sinc3Sel <= 1'b0;
      rateSel <= RATE_4000SPS;
      do_reset();
      kick(1'b1);
      wait_ready(20000, t2);
      cmp_word(dataOut, OFS + SIG);
      cmp_flag(inputSwap, 1'b0);
      cmp_flag(convBusy, 1'b0);
   endtask

   // chop on, continuous: offset cancels, later results come twice as fast
   task automatic sc_chop_cont();
      chopEn <= 1'b1;
      contMode <= 1'b1;
      sinc3Sel <= 1'b0;
      rateSel <= RATE_4000SPS;
      do_reset();
      kick(1'b0);
      #1;
      cmp_word(periodLen, CHOP_4K_FIRST);
      wait_ready(20000, t1);
      cmp_word(dataOut, SIG);
      cmp_flag(t1 >= 208 * MOD_DIV, 1'b1);
      wait_ready(20000, t2);
      cmp_word(dataOut, SIG);
      cmp_word(periodLen, CHOP_4K_NEXT);
      cmp_flag(t2 * 8 >= t1 * 3 && t2 * 8 <= t1 * 5, 1'b1);
   endtask

   // sinc3 with chop needs several more conversions before the first result
   task automatic sc_sinc3();
      sinc3Sel <= 1'b1;
      do_reset();
      kick(1'b1);
      wait_ready(40000, ts);
      cmp_word(dataOut, SIG);
      cmp_flag(ts * 4 > t1 * 7, 1'b1);
   endtask

   // main sequence; delay code and stop stay idle on purpose
   initial begin
      errors = 0;
      compares = 0;
      rstn = 1'b0;
      chopEn = 1'b0;
      sinc3Sel = 1'b0;
      contMode = 1'b0;
      rateSel = '0;
      delaySel = '0;
      startPin = 1'b0;
      startCmd = 1'b0;
      stopReq = 1'b0;
      do_reset();
      sc_line_reject();
      sc_plain();
      sc_chop_cont();
      sc_sinc3();
      test_done();
   end
endmodule
